// ==== rtl/itxirq_pkg.sv ====
/*
 * itxirq_pkg: offsets, widths and reset values for the transmit
 * context interrupt event, mask and control registers.
 * assumes a 32-bit register port with byte addresses.
 */
package itxirq_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          NUM_CTX      = 8;
    localparam logic [7:0]  EVENT_SET    = 8'h90;
    localparam logic [7:0]  EVENT_CLEAR  = 8'h94;
    localparam logic [7:0]  MASK_SET     = 8'h98;
    localparam logic [7:0]  MASK_CLEAR   = 8'h9C;
    localparam logic [7:0]  CTRL_REG     = 8'hA0;
    localparam int          CTRL_GIE_BIT = 0;
    localparam logic [7:0]  EVENT_RESET  = 8'h00;
    localparam logic [7:0]  MASK_RESET   = 8'h00;
    localparam logic        GIE_RESET    = 1'b0;
endpackage

// ==== rtl/itxirq_regs.sv ====
/*
 * itxirq_regs: per-context event latch, enable mask and summary
 * interrupt for the isochronous transmit contexts.
 * assumes context completion signals come from logic on clk_i and a
 * single-cycle register port with no wait states.
 */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - a request needs last-descriptor completion and interrupt bits.
// - an event bit sets on the rising edge of its request and stays set.
// - ones written at event set set those bits, zeros change nothing.
// - an event bit clears only by a one written at event clear.
// - event clear reads event AND mask, event set reads raw events.
// - bits 31 to 8 ignore writes and read as zero.
// - event bit n belongs to transmit context n.
// - mask bit n gates event bit n into the summary.
// - both mask addresses read the unmodified mask.
// - the summary is unlatched, the OR of event AND mask.
// - with global enable clear, the external interrupt stays low.
module itxirq_regs #(
    parameter int NUM_CTX = itxirq_pkg::NUM_CTX
) (
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire logic [NUM_CTX-1:0]            ctx_done_i,
    input  wire logic [NUM_CTX-1:0]            ctx_irq_bits_i,
    input  wire logic [itxirq_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [itxirq_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [itxirq_pkg::DATA_W-1:0] rdata_o,
    output logic                               tx_context_summary_irq_o,
    output logic                               irq_o
);

    logic [NUM_CTX-1:0] event_q;
    logic [NUM_CTX-1:0] mask_q;
    logic [NUM_CTX-1:0] req_q;
    logic [NUM_CTX-1:0] req_d;
    logic [NUM_CTX-1:0] rise;
    logic [NUM_CTX-1:0] wset_ev;
    logic [NUM_CTX-1:0] wclr_ev;
    logic               global_irq_enable_q;
    logic [itxirq_pkg::DATA_W-1:0] rdata_d;

    // request needs both completion and descriptor interrupt bits
    assign req_d = ctx_done_i & ctx_irq_bits_i;
    assign rise  = req_d & ~req_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            req_q <= '0;
        else
            req_q <= req_d;
    end

    // only the low bits are decoded, upper data bits are dropped
    assign wset_ev = (wr_i && addr_i == itxirq_pkg::EVENT_SET)
                     ? wdata_i[NUM_CTX-1:0] : '0;
    assign wclr_ev = (wr_i && addr_i == itxirq_pkg::EVENT_CLEAR)
                     ? wdata_i[NUM_CTX-1:0] : '0;

    // set wins over a same-cycle clear so no event is lost
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            event_q <= itxirq_pkg::EVENT_RESET[NUM_CTX-1:0];
        else
            event_q <= (event_q & ~wclr_ev) | wset_ev
                       | rise;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            mask_q <= itxirq_pkg::MASK_RESET[NUM_CTX-1:0];
        else if (wr_i && addr_i == itxirq_pkg::MASK_SET)
            mask_q <= mask_q | wdata_i[NUM_CTX-1:0];
        else if (wr_i && addr_i == itxirq_pkg::MASK_CLEAR)
            mask_q <= mask_q & ~wdata_i[NUM_CTX-1:0];
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            global_irq_enable_q <= itxirq_pkg::GIE_RESET;
        else if (wr_i && addr_i == itxirq_pkg::CTRL_REG)
            global_irq_enable_q <= wdata_i[itxirq_pkg::CTRL_GIE_BIT];
    end

    assign tx_context_summary_irq_o = |(event_q & mask_q);
    assign irq_o = tx_context_summary_irq_o & global_irq_enable_q;

    always_comb
    begin
        rdata_d = '0;
        unique case (addr_i)
            itxirq_pkg::EVENT_SET:   rdata_d[NUM_CTX-1:0] = event_q;
            itxirq_pkg::EVENT_CLEAR:
                rdata_d[NUM_CTX-1:0] = event_q & mask_q;
            itxirq_pkg::MASK_SET:    rdata_d[NUM_CTX-1:0] = mask_q;
            itxirq_pkg::MASK_CLEAR:  rdata_d[NUM_CTX-1:0] = mask_q;
            itxirq_pkg::CTRL_REG:
                rdata_d[itxirq_pkg::CTRL_GIE_BIT] = global_irq_enable_q;
            default:                 rdata_d = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= '0;
        else if (rd_i)
            rdata_o <= rdata_d;
        else
            rdata_o <= '0;
    end

    // per-context checks share one body so every context is covered
    for (genvar k = 0; k < NUM_CTX; k++)
    begin : g_ctx_chk
        property p_edge_sets;
            @(posedge clk_i) disable iff (!rstn_i)
            (req_d[k] && !req_q[k]) |=> event_q[k];
        endproperty
        a_edge_sets: assert property (p_edge_sets)
            else $error("context edge did not set event");

        property p_level_no_set;
            @(posedge clk_i) disable iff (!rstn_i)
            (req_q[k] && req_d[k] && !event_q[k] && !wset_ev[k])
            |=> !event_q[k];
        endproperty
        a_level_no_set: assert property (p_level_no_set)
            else $error("steady level set an event");

        property p_req_needs_both;
            @(posedge clk_i) disable iff (!rstn_i)
            (ctx_done_i[k] && !ctx_irq_bits_i[k] && !event_q[k]
             && !wset_ev[k]) |=> !event_q[k];
        endproperty
        a_req_needs_both: assert property (p_req_needs_both)
            else $error("event set without interrupt bits");

        property p_hold;
            @(posedge clk_i) disable iff (!rstn_i)
            (event_q[k] && !(wr_i && addr_i == itxirq_pkg::EVENT_CLEAR
                             && wdata_i[k])) |=> event_q[k];
        endproperty
        a_hold: assert property (p_hold)
            else $error("event cleared without clear write");

        // a rising request in the same cycle wins over the clear
        property p_eclr;
            @(posedge clk_i) disable iff (!rstn_i)
            (wr_i && addr_i == itxirq_pkg::EVENT_CLEAR && wdata_i[k]
             && !rise[k]) |=> !event_q[k];
        endproperty
        a_eclr: assert property (p_eclr)
            else $error("clear write left event set");

        property p_set_zero;
            @(posedge clk_i) disable iff (!rstn_i)
            (wr_i && addr_i == itxirq_pkg::EVENT_SET && !wdata_i[k]
             && !event_q[k] && !rise[k]) |=> !event_q[k];
        endproperty
        a_set_zero: assert property (p_set_zero)
            else $error("zero written at set address set event");

        property p_summary;
            @(posedge clk_i) disable iff (!rstn_i)
            (event_q[k] && mask_q[k]) |-> tx_context_summary_irq_o;
        endproperty
        a_summary: assert property (p_summary)
            else $error("summary missing for enabled event");

        property p_mclr;
            @(posedge clk_i) disable iff (!rstn_i)
            (wr_i && addr_i == itxirq_pkg::MASK_CLEAR && wdata_i[k])
            |=> !mask_q[k];
        endproperty
        a_mclr: assert property (p_mclr)
            else $error("mask clear failed");

        property p_mset;
            @(posedge clk_i) disable iff (!rstn_i)
            (wr_i && addr_i == itxirq_pkg::MASK_SET && wdata_i[k])
            |=> mask_q[k];
        endproperty
        a_mset: assert property (p_mset)
            else $error("mask set failed");

        property p_mask_hold;
            @(posedge clk_i) disable iff (!rstn_i)
            !(wr_i && (addr_i == itxirq_pkg::MASK_SET
                       || addr_i == itxirq_pkg::MASK_CLEAR))
            |=> (mask_q[k] == $past(mask_q[k]));
        endproperty
        a_mask_hold: assert property (p_mask_hold)
            else $error("mask changed without mask write");
    end

    property p_wset;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_i && addr_i == itxirq_pkg::EVENT_SET) |=>
        ((event_q & $past(wdata_i[NUM_CTX-1:0])) ==
         $past(wdata_i[NUM_CTX-1:0]));
    endproperty
    a_wset: assert property (p_wset)
        else $error("event set write missed a bit");

    property p_rd_masked;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_i && addr_i == itxirq_pkg::EVENT_CLEAR && !wr_i) |=>
        (rdata_o[NUM_CTX-1:0] == $past(event_q & mask_q));
    endproperty
    a_rd_masked: assert property (p_rd_masked)
        else $error("clear address read not masked");

    property p_rd_raw;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_i && addr_i == itxirq_pkg::EVENT_SET) |=>
        (rdata_o[NUM_CTX-1:0] == $past(event_q));
    endproperty
    a_rd_raw: assert property (p_rd_raw)
        else $error("set address read not raw");

    // reserved bits never carry state, so they must read zero always
    property p_rd_upper;
        @(posedge clk_i) disable iff (!rstn_i)
        rdata_o[itxirq_pkg::DATA_W-1:NUM_CTX] == '0;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("reserved read bits not zero");

    property p_rd_idle;
        @(posedge clk_i) disable iff (!rstn_i)
        !rd_i |=> (rdata_o == '0);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");

    property p_rd_unmapped;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_i && addr_i != itxirq_pkg::EVENT_SET
         && addr_i != itxirq_pkg::EVENT_CLEAR
         && addr_i != itxirq_pkg::MASK_SET
         && addr_i != itxirq_pkg::MASK_CLEAR
         && addr_i != itxirq_pkg::CTRL_REG) |=> (rdata_o == '0);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");

    property p_rd_mset;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_i && addr_i == itxirq_pkg::MASK_SET) |=>
        (rdata_o[NUM_CTX-1:0] == $past(mask_q));
    endproperty
    a_rd_mset: assert property (p_rd_mset)
        else $error("mask set read wrong");

    property p_rd_mask;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_i && addr_i == itxirq_pkg::MASK_CLEAR) |=>
        (rdata_o[NUM_CTX-1:0] == $past(mask_q));
    endproperty
    a_rd_mask: assert property (p_rd_mask)
        else $error("mask read wrong");

    property p_masked_off;
        @(posedge clk_i) disable iff (!rstn_i)
        ((event_q & mask_q) == '0) |-> !tx_context_summary_irq_o;
    endproperty
    a_masked_off: assert property (p_masked_off)
        else $error("summary raised by masked event");

    property p_gie;
        @(posedge clk_i) disable iff (!rstn_i)
        !global_irq_enable_q |-> !irq_o;
    endproperty
    a_gie: assert property (p_gie)
        else $error("interrupt while globally disabled");

    property p_gie_on;
        @(posedge clk_i) disable iff (!rstn_i)
        (global_irq_enable_q && tx_context_summary_irq_o) |-> irq_o;
    endproperty
    a_gie_on: assert property (p_gie_on)
        else $error("interrupt missing while enabled");

    property p_irq_needs_summary;
        @(posedge clk_i) disable iff (!rstn_i)
        !tx_context_summary_irq_o |-> !irq_o;
    endproperty
    a_irq_needs_summary: assert property (p_irq_needs_summary)
        else $error("interrupt without summary");

    property p_gie_write;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_i && addr_i == itxirq_pkg::CTRL_REG) |=>
        (global_irq_enable_q == $past(wdata_i[itxirq_pkg::CTRL_GIE_BIT]));
    endproperty
    a_gie_write: assert property (p_gie_write)
        else $error("global enable write lost");

    property p_rd_gie;
        @(posedge clk_i) disable iff (!rstn_i)
        (rd_i && addr_i == itxirq_pkg::CTRL_REG) |=>
        (rdata_o[itxirq_pkg::CTRL_GIE_BIT] == $past(global_irq_enable_q));
    endproperty
    a_rd_gie: assert property (p_rd_gie)
        else $error("global enable read wrong");

endmodule

`default_nettype wire

// ==== sim/itxirq_regs_tb.sv ====
/*
 * itxirq_regs_tb: register-port bench for the transmit context irq block.
 * assumes rtl/itxirq_pkg.sv and rtl/itxirq_regs.sv compile first.
 */
`timescale 1ns/1ns
`default_nettype none
module itxirq_regs_tb;
    logic        clk_i    = 1'b0;
    logic        rstn_i   = 1'b0;
    logic [7:0]  ctx_done = 8'h00;
    logic [7:0]  ctx_bits = 8'h00;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wdata    = 32'h0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [31:0] rdata;
    logic        summary;
    logic        irq;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles   = 0;

    initial forever #4 clk_i = ~clk_i;

    itxirq_regs i_itxirq_regs (.clk_i(clk_i), .rstn_i(rstn_i),
        .ctx_done_i(ctx_done), .ctx_irq_bits_i(ctx_bits), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .tx_context_summary_irq_o(summary), .irq_o(irq));

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ceiling well above the fewer than 100 cycles the sequence needs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd_reg(8'h90, 32'h0);
        rd_reg(8'h98, 32'h0);
        wr_reg(8'h90, 32'hFFFFFF05);
        rd_reg(8'h90, 32'h00000005);
        wr_reg(8'h94, 32'h00000001);
        wr_reg(8'h90, 32'h00000000);
        rd_reg(8'h90, 32'h00000004);
        wr_reg(8'h98, 32'hFFFFFF0C);
        rd_reg(8'h98, 32'h0000000C);
        rd_reg(8'h9C, 32'h0000000C);
        rd_reg(8'h94, 32'h00000004);
        chk("summary", summary, 1'b1);
        rd_reg(8'h90, 32'h00000004);
        chk("irq", irq, 1'b0);
        wr_reg(8'hA0, 32'h00000001);
        chk("irq", irq, 1'b1);
        wr_reg(8'h9C, 32'h00000004);
        rd_reg(8'h98, 32'h00000008);
        chk("summary", summary, 1'b0);
        chk("irq", irq, 1'b0);
        @(posedge clk_i);
        ctx_done <= 8'h80;
        repeat (3) @(posedge clk_i);
        rd_reg(8'h90, 32'h00000004);
        @(posedge clk_i);
        ctx_bits <= 8'h80;
        repeat (3) @(posedge clk_i);
        rd_reg(8'h90, 32'h00000084);
        wr_reg(8'h94, 32'h00000080);
        repeat (3) @(posedge clk_i);
        rd_reg(8'h90, 32'h00000004);
        @(posedge clk_i);
        ctx_done <= 8'h00;
        rd_reg(8'hA4, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
